/* rtl/bsdr_map.vh */
/*
 Constants of the boundary-scan data register block: chain lengths, cell
 positions, instruction codes. Assumes it is included by bare name.
*/
`ifndef BSDR_MAP_VH
`define BSDR_MAP_VH

// ----------------------------------------------------------------------
// Chain geometry
// ----------------------------------------------------------------------
`define BSDR_LEN_FULL 126
`define BSDR_LEN_REDUCED 118
`define BSDR_NPINS 45
`define BSDR_NCAN 2
`define BSDR_NUPD 94

// ----------------------------------------------------------------------
// Cell positions
// ----------------------------------------------------------------------
`define BSDR_CELL_RST_EN 0
`define BSDR_CELL_RST_IN 1
`define BSDR_CELL_CAN_BASE 2
`define BSDR_CELL_XTAL 6
`define BSDR_CELL_PULLUP 7
`define BSDR_CELL_PORT_BASE 8

// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define BSDR_IR_W 16
`define BSDR_IR_EXTEST 16'h0000
`define BSDR_IR_SAMPLE 16'h0002
`define BSDR_IR_BYPASS 16'hffff
`define BSDR_IR_CAPTURE 16'h0001

`endif

/* rtl/bsdr_boundary_scan.v */
/*
 Boundary-scan data register chain with its test access port controller.
 Assumes test pins, pin inputs, the crystal input and the variant strap are
 asynchronous to clk_sys and much slower than it (test clock at least
 four system clocks per half period).
*/
// Overview of operation
// - Chain is 126 bits, or 118 reduced.
// - Chain observes pins under EXTEST/SAMPLE, controls them under EXTEST only.
// - EXTEST performs capture and update of cells.
// - SAMPLE captures and loads the update stage, never drives pins.
// - Cell 0: reset-drive enable, captured and updated.
// - Cell 1 captures reset pin; update ignored.
// - Cells 2, 4: CAN pin output enables.
// - Cell 3: CAN receive pin data.
// - Cell 5: CAN transmit pin data.
// - Cell 6 captures crystal input; update unused.
// - Cell 7: weak pull-up enable.
// - Even cells 8-22: port 0 enables.
// - Odd cells 9-23: port 0 data.
// - Cells 24-39 serve port 1 alike.
// - Cells 40-55 serve port 2 alike.
// - Cells 56-71 serve port 3 alike.
// - Cells 72, 74, 76: port 4 enables.
// - Cells 73, 75, 77: port 4 data.
// - Even cells 78-92: port 5 enables.
// - Odd cells 79-93: port 5 data.
// - Chain reached only through four test pins.
`timescale 1ns/1ns
`include "bsdr_map.vh"

module bsdr_boundary_scan (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Test pins
  input wire tck_pin,
  input wire tms_pin,
  input wire tdi_pin,
  output reg tdo_pin,
  output reg tdo_oe_b,
  // Variant strap
  input wire variant_reduced,
  // Reset pin, open drain
  input wire rst_pin_in,
  output reg rst_pin_out,
  output reg rst_pin_oe_b,
  // Crystal input pin
  input wire crystal_input_pin,
  // CAN pins, bit 0 receive, bit 1 transmit
  input wire [1:0] can_pin_in,
  output wire [1:0] can_pin_out,
  output wire [1:0] can_pin_oe_b,
  // Port 0 to 3 pins
  input wire [7:0] port0_pin_in,
  output wire [7:0] port0_pin_out,
  output wire [7:0] port0_pin_oe_b,
  input wire [7:0] port1_pin_in,
  output wire [7:0] port1_pin_out,
  output wire [7:0] port1_pin_oe_b,
  input wire [7:0] port2_pin_in,
  output wire [7:0] port2_pin_out,
  output wire [7:0] port2_pin_oe_b,
  input wire [7:0] port3_pin_in,
  output wire [7:0] port3_pin_out,
  output wire [7:0] port3_pin_oe_b,
  // Port 4 pins 5 to 7 and port 5 pins
  input wire [2:0] port4_pin_in,
  output wire [2:0] port4_pin_out,
  output wire [2:0] port4_pin_oe_b,
  input wire [7:0] port5_pin_in,
  output wire [7:0] port5_pin_out,
  output wire [7:0] port5_pin_oe_b,
  // Weak pull-up enable to port pins
  output reg weak_pullup_en,
  // Core side, active high enables
  input wire core_rst_drive,
  input wire core_pullup_en,
  input wire [1:0] core_can_out,
  input wire [1:0] core_can_oe,
  input wire [7:0] core_port0_out,
  input wire [7:0] core_port0_oe,
  input wire [7:0] core_port1_out,
  input wire [7:0] core_port1_oe,
  input wire [7:0] core_port2_out,
  input wire [7:0] core_port2_oe,
  input wire [7:0] core_port3_out,
  input wire [7:0] core_port3_oe,
  input wire [2:0] core_port4_out,
  input wire [2:0] core_port4_oe,
  input wire [7:0] core_port5_out,
  input wire [7:0] core_port5_oe,
  // Test mode status to the core
  output reg extest_active
);

  // ----------------------------------------------------------------------
  // TAP states
  // ----------------------------------------------------------------------
  localparam [3:0] ST_TLR = 4'h0;
  localparam [3:0] ST_RTI = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SHF_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PAU_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'ha;
  localparam [3:0] ST_SHF_IR = 4'hb;
  localparam [3:0] ST_EX1_IR = 4'hc;
  localparam [3:0] ST_PAU_IR = 4'hd;
  localparam [3:0] ST_EX2_IR = 4'he;
  localparam [3:0] ST_UPD_IR = 4'hf;

  localparam NP = `BSDR_NPINS;
  localparam LEN = `BSDR_LEN_FULL;
  localparam LENR = `BSDR_LEN_REDUCED;
  localparam NA = NP + 6;

  // Cell of a pin's output enable; its data cell follows it
  function integer cell_of;
    input integer j;
    begin
      if (j < `BSDR_NCAN) begin
        cell_of = `BSDR_CELL_CAN_BASE + 2 * j;
      end else begin
        cell_of = `BSDR_CELL_PORT_BASE + 2 * (j - `BSDR_NCAN);
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin vectors, index 0 CAN receive up to 44 port 5 pin 7
  // ----------------------------------------------------------------------
  wire [NP-1:0] pin_in_a = {port5_pin_in, port4_pin_in, port3_pin_in, port2_pin_in,
                            port1_pin_in, port0_pin_in, can_pin_in};
  wire [NP-1:0] core_out = {core_port5_out, core_port4_out, core_port3_out,
                            core_port2_out, core_port1_out, core_port0_out, core_can_out};
  wire [NP-1:0] core_oe = {core_port5_oe, core_port4_oe, core_port3_oe,
                           core_port2_oe, core_port1_oe, core_port0_oe, core_can_oe};
  reg [NP-1:0] pin_out_q;
  reg [NP-1:0] pin_oe_b_q;

  assign {port5_pin_out, port4_pin_out, port3_pin_out, port2_pin_out,
          port1_pin_out, port0_pin_out, can_pin_out} = pin_out_q;
  assign {port5_pin_oe_b, port4_pin_oe_b, port3_pin_oe_b, port2_pin_oe_b,
          port1_pin_oe_b, port0_pin_oe_b, can_pin_oe_b} = pin_oe_b_q;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Test pins, pin inputs, reset pin, crystal input and strap all pass two flops
  wire [NA-1:0] async_in = {variant_reduced, crystal_input_pin, rst_pin_in, pin_in_a,
                            tdi_pin, tms_pin, tck_pin};
  reg [NA-1:0] sync1_q;
  reg [NA-1:0] sync2_q;
  reg tck_prev_q;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sync1_q <= {NA{1'b0}};
      sync2_q <= {NA{1'b0}};
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      tck_prev_q <= sync2_q[0];
    end
  end

  wire tck_s = sync2_q[0];
  wire tms_s = sync2_q[1];
  wire tdi_s = sync2_q[2];
  wire [NP-1:0] pin_in_s = sync2_q[NP+2:3];
  wire rst_in_s = sync2_q[NP+3];
  wire xtal_s = sync2_q[NP+4];
  wire reduced_s = sync2_q[NP+5];
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;

  // ----------------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------------
  reg [3:0] state_q;
  reg [3:0] state_d;

  always @* begin
    case (state_q)
      ST_TLR: state_d = tms_s ? ST_TLR : ST_RTI;
      ST_RTI: state_d = tms_s ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: state_d = tms_s ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = tms_s ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_d = tms_s ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: state_d = tms_s ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = tms_s ? ST_UPD_IR : ST_SHF_IR;
      default: state_d = tms_s ? ST_SEL_DR : ST_RTI;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= ST_TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------------
  reg [`BSDR_IR_W-1:0] ir_sr_q;
  reg [`BSDR_IR_W-1:0] ir_q;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ir_sr_q <= `BSDR_IR_CAPTURE;
      ir_q <= `BSDR_IR_BYPASS;
    end else begin
      if (tck_rise && state_q == ST_CAP_IR) begin
        ir_sr_q <= `BSDR_IR_CAPTURE;
      end else if (tck_rise && state_q == ST_SHF_IR) begin
        ir_sr_q <= {tdi_s, ir_sr_q[`BSDR_IR_W-1:1]};
      end
      // Bypass after test reset keeps the pins with the core
      if (tck_fall && state_q == ST_TLR) begin
        ir_q <= `BSDR_IR_BYPASS;
      end else if (tck_fall && state_q == ST_UPD_IR) begin
        ir_q <= ir_sr_q;
      end
    end
  end

  wire sel_extest = (ir_q == `BSDR_IR_EXTEST);
  wire sel_bsr = sel_extest | (ir_q == `BSDR_IR_SAMPLE);

  // ----------------------------------------------------------------------
  // Capture vector
  // ----------------------------------------------------------------------
  wire [LEN-1:0] cap_vec;

  assign cap_vec[`BSDR_CELL_RST_EN] = core_rst_drive;
  assign cap_vec[`BSDR_CELL_RST_IN] = rst_in_s;
  assign cap_vec[`BSDR_CELL_XTAL] = xtal_s;
  assign cap_vec[`BSDR_CELL_PULLUP] = core_pullup_en;
  // Cells beyond the port 5 group are outside this block
  assign cap_vec[LEN-1:`BSDR_NUPD] = {(LEN - `BSDR_NUPD){1'b0}};

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_cap
      assign cap_vec[cell_of(g)] = core_oe[g];
      assign cap_vec[cell_of(g) + 1] = pin_in_s[g];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Boundary shift and update stages
  // ----------------------------------------------------------------------
  reg [LEN-1:0] bsr_q;
  reg [LEN-1:0] bsr_d;
  reg [`BSDR_NUPD-1:0] upd_q;
  reg byp_q;

  always @* begin
    bsr_d = {tdi_s, bsr_q[LEN-1:1]};
    // Short chain enters at its own top cell
    if (reduced_s) begin
      bsr_d[LEN-1:LENR] = {(LEN - LENR){1'b0}};
      bsr_d[LENR-1] = tdi_s;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      bsr_q <= {LEN{1'b0}};
      upd_q <= {`BSDR_NUPD{1'b0}};
      byp_q <= 1'b0;
    end else begin
      if (tck_rise && state_q == ST_CAP_DR) begin
        if (sel_bsr) begin
          bsr_q <= cap_vec;
        end
        byp_q <= 1'b0;
      end else if (tck_rise && state_q == ST_SHF_DR) begin
        if (sel_bsr) begin
          bsr_q <= bsr_d;
        end
        byp_q <= tdi_s;
      end
      // SAMPLE also presets the update stage; pins only see it in EXTEST
      if (tck_fall && state_q == ST_UPD_DR && sel_bsr) begin
        upd_q <= bsr_q[`BSDR_NUPD-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Test data out, changes on the falling test clock
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      tdo_pin <= 1'b0;
      tdo_oe_b <= 1'b1;
    end else if (tck_fall) begin
      if (state_q == ST_SHF_DR) begin
        tdo_pin <= sel_bsr ? bsr_q[0] : byp_q;
        tdo_oe_b <= 1'b0;
      end else if (state_q == ST_SHF_IR) begin
        tdo_pin <= ir_sr_q[0];
        tdo_oe_b <= 1'b0;
      end else begin
        tdo_oe_b <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive multiplexers
  // ----------------------------------------------------------------------
  // Registered for clean pin timing, at the cost of one clock of latency
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_pin
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          pin_out_q[g] <= 1'b0;
          pin_oe_b_q[g] <= 1'b1;
        end else if (sel_extest) begin
          pin_out_q[g] <= upd_q[cell_of(g) + 1];
          pin_oe_b_q[g] <= ~upd_q[cell_of(g)];
        end else begin
          pin_out_q[g] <= core_out[g];
          pin_oe_b_q[g] <= ~core_oe[g];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rst_pin_out <= 1'b0;
      rst_pin_oe_b <= 1'b1;
      weak_pullup_en <= 1'b0;
      extest_active <= 1'b0;
    end else begin
      // Open drain: only ever pulls low
      rst_pin_out <= 1'b0;
      extest_active <= sel_extest;
      if (sel_extest) begin
        rst_pin_oe_b <= ~upd_q[`BSDR_CELL_RST_EN];
        weak_pullup_en <= upd_q[`BSDR_CELL_PULLUP];
      end else begin
        rst_pin_oe_b <= ~core_rst_drive;
        weak_pullup_en <= core_pullup_en;
      end
    end
  end

endmodule // bsdr_boundary_scan

/* testbench/bsdr_jtag_ctrl.sv */
/*
 Test controller model: drives tck, tms, tdi and samples tdo at tck rise.
 Assumes clk_sys from the bench; tck period is 20 clk (160 ns).
*/
`timescale 1ns/1ns
module bsdr_jtag_ctrl (
  // Clock
  input wire clk_sys,
  // Test pins
  output reg tck_pin,
  output reg tms_pin,
  output reg tdi_pin,
  input wire tdo_pin
);
  reg tdo_q;
  // Tck stands low between frames
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b0;
  end
  // Changes only while tck low, tdo taken at the rise
  task tick(input reg tms, input reg tdi);
    begin
      tms_pin = tms;
      tdi_pin = tdi;
      repeat (10) @(negedge clk_sys);
      tck_pin = 1'b1;
      tdo_q = tdo_pin;
      repeat (10) @(negedge clk_sys);
      tck_pin = 1'b0;
    end
  endtask
  // Tdi toggles when not shifting, so no stale level is trusted
  task nav(input reg tms);
    tick(tms, ~tdi_pin);
  endtask
  task reset_tap;
    begin
      repeat (5) nav(1'b1);
      nav(1'b0);
    end
  endtask
  // Instruction codes 0x0000 and 0x0002 select the chain
  task load_ir(input reg [15:0] code);
    integer i;
    begin
      nav(1'b1);
      nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (i = 0; i < 16; i = i + 1) tick(i == 15, code[i]);
      nav(1'b1);
      nav(1'b0);
    end
  endtask
  task scan_dr(input reg [131:0] din, input integer n, output reg [131:0] dout);
    integer i;
    begin
      dout = 132'h0;
      nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (i = 0; i < n; i = i + 1) begin
        tick(i == n - 1, din[i]);
        dout[i] = tdo_q;
      end
      nav(1'b1);
      nav(1'b0);
    end
  endtask
endmodule // bsdr_jtag_ctrl

/* testbench/bsdr_assertions.sv */
/*
 Checker of the boundary-scan block ports. Assumes one clock domain and a
 synchronous active-low reset; bound to every instance of the block.
*/
`timescale 1ns/1ns
module bsdr_assertions (
  input wire clk_sys,
  input wire rst_b,
  input wire tck_pin,
  input wire tdo_pin,
  input wire tdo_oe_b,
  input wire rst_pin_out,
  input wire rst_pin_oe_b,
  input wire weak_pullup_en,
  input wire extest_active,
  input wire core_pullup_en,
  input wire core_rst_drive,
  input wire [1:0] core_can_out,
  input wire [1:0] can_pin_out,
  input wire [7:0] core_port0_out,
  input wire [7:0] port0_pin_out,
  input wire [7:0] core_port1_oe,
  input wire [7:0] port1_pin_oe_b,
  input wire [7:0] port2_pin_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Core owns the pins once settled outside the test instruction
  sequence fn_s;
    (rst_b && !extest_active) [*3];
  endsequence
  pass_data_a: assert property (fn_s |-> port0_pin_out == $past(core_port0_out))
    else $error("port data not from core");
  pass_enable_a: assert property (fn_s |-> port1_pin_oe_b == ~$past(core_port1_oe))
    else $error("port enable not from core");
  pass_can_a: assert property (fn_s |-> can_pin_out == $past(core_can_out))
    else $error("can data not from core");
  pass_pullup_a: assert property (fn_s |-> weak_pullup_en == $past(core_pullup_en))
    else $error("pull-up not from core");
  pass_reset_a: assert property (fn_s |-> rst_pin_oe_b == !$past(core_rst_drive))
    else $error("reset drive not from core");
  rst_out_low_a: assert property (rst_pin_out == 1'b0)
    else $error("reset pin driven high");
  reset_state_a: assert property (disable iff (1'b0) !rst_b |=>
    (tdo_oe_b && rst_pin_oe_b && !weak_pullup_en && !extest_active))
    else $error("outputs not idle after reset");
  tdo_fall_a: assert property ($changed(tdo_pin) |-> !tck_pin && !$past(tck_pin))
    else $error("tdo moved outside tck low");
  update_fall_a: assert property (extest_active && $changed(port2_pin_out) |->
    !tck_pin && !$past(tck_pin))
    else $error("pin update outside tck low");
endmodule // bsdr_assertions

bind bsdr_boundary_scan bsdr_assertions u_chk (.clk_sys, .rst_b, .tck_pin, .tdo_pin,
  .tdo_oe_b, .rst_pin_out, .rst_pin_oe_b, .weak_pullup_en, .extest_active, .core_pullup_en,
  .core_rst_drive, .core_can_out, .can_pin_out, .core_port0_out, .port0_pin_out,
  .core_port1_oe, .port1_pin_oe_b, .port2_pin_out);

/* testbench/boundary_scan_data_register_test.sv */
/*
 Self-checking bench of the boundary-scan block. Assumes the controller
 model and the checker are compiled alongside; both chain variants.
*/
`timescale 1ns/1ns
module boundary_scan_data_register_test;
  reg clk_sys = 1'b0, rst_b = 1'b0, rst_pin_in = 1'b1, xtal = 1'b0;
  reg core_rst = 1'b1, core_pu = 1'b1, reduced = 1'b0;
  reg [1:0] can_in = 2'h2, core_can_out = 2'h1, core_can_oe = 2'h3;
  reg [42:0] pin_in = 43'h5a5a5a5a5a5, core_out = 43'h1234567, core_oe = 43'h7f00ff00f0f;
  wire tck, tms, tdi, tdo, tdo_oe_b, rst_pin_out, rst_pin_oe_b, pu_en, ext;
  wire [1:0] can_out, can_oe_b;
  wire [42:0] pin_out, pin_oe_b;
  integer fail_count = 0, samples_checked = 0;
  reg [131:0] cap, pat;
  always #4 clk_sys = ~clk_sys;
  bsdr_jtag_ctrl u_ctrl (.clk_sys, .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi), .tdo_pin(tdo));
  bsdr_boundary_scan DUT (.clk_sys, .rst_b, .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
    .tdo_pin(tdo), .tdo_oe_b, .variant_reduced(reduced), .rst_pin_in, .rst_pin_out,
    .rst_pin_oe_b, .crystal_input_pin(xtal), .can_pin_in(can_in), .can_pin_out(can_out),
    .can_pin_oe_b(can_oe_b), .port0_pin_in(pin_in[7:0]), .port0_pin_out(pin_out[7:0]),
    .port0_pin_oe_b(pin_oe_b[7:0]), .port1_pin_in(pin_in[15:8]),
    .port1_pin_out(pin_out[15:8]), .port1_pin_oe_b(pin_oe_b[15:8]),
    .port2_pin_in(pin_in[23:16]), .port2_pin_out(pin_out[23:16]),
    .port2_pin_oe_b(pin_oe_b[23:16]), .port3_pin_in(pin_in[31:24]),
    .port3_pin_out(pin_out[31:24]), .port3_pin_oe_b(pin_oe_b[31:24]),
    .port4_pin_in(pin_in[34:32]), .port4_pin_out(pin_out[34:32]),
    .port4_pin_oe_b(pin_oe_b[34:32]), .port5_pin_in(pin_in[42:35]),
    .port5_pin_out(pin_out[42:35]), .port5_pin_oe_b(pin_oe_b[42:35]),
    .weak_pullup_en(pu_en), .core_rst_drive(core_rst), .core_pullup_en(core_pu),
    .core_can_out, .core_can_oe, .core_port0_out(core_out[7:0]), .core_port0_oe(core_oe[7:0]),
    .core_port1_out(core_out[15:8]), .core_port1_oe(core_oe[15:8]),
    .core_port2_out(core_out[23:16]), .core_port2_oe(core_oe[23:16]),
    .core_port3_out(core_out[31:24]), .core_port3_oe(core_oe[31:24]),
    .core_port4_out(core_out[34:32]), .core_port4_oe(core_oe[34:32]),
    .core_port5_out(core_out[42:35]), .core_port5_oe(core_oe[42:35]), .extest_active(ext));
  task check(input reg [131:0] seen, input reg [131:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task check_pins(input reg r, input reg [1:0] co, ce, input reg p, input reg [42:0] o, e);
    check({rst_pin_oe_b, can_out, can_oe_b, pu_en, pin_out, pin_oe_b}, {~r, co, ~ce, p, o, ~e});
  endtask
  // Expected capture: 0 reset en, 1 reset pin, 2-5 CAN, 6 crystal, 7 pull-up, 8+ pins
  function [131:0] exp_cap(input reg dummy);
    integer n;
    begin
      exp_cap = 132'h0;
      exp_cap[7:0] = {core_pu, xtal, can_in[1], core_can_oe[1], can_in[0], core_can_oe[0],
        rst_pin_in, core_rst};
      for (n = 0; n < 43; n = n + 1) begin
        exp_cap[8 + 2 * n] = core_oe[n];
        exp_cap[9 + 2 * n] = pin_in[n];
      end
    end
  endfunction
  task t_sample;
    begin
      u_ctrl.load_ir(16'h0002);
      pat = {11{12'h5a3}};
      u_ctrl.scan_dr(pat, 132, cap);
      check(cap[125:0], exp_cap(1'b0));
      check(cap[131:126], pat[5:0]);
      check(ext, 1'b0);
      check_pins(core_rst, core_can_out, core_can_oe, core_pu, core_out, core_oe);
    end
  endtask
  task t_extest(input reg [131:0] v);
    integer n;
    reg [42:0] o, e;
    begin
      u_ctrl.load_ir(16'h0000);
      check(ext, 1'b1);
      u_ctrl.scan_dr(v, 126, cap);
      check(cap[125:0], exp_cap(1'b0));
      repeat (8) @(negedge clk_sys);
      for (n = 0; n < 43; n = n + 1) begin
        o[n] = v[9 + 2 * n];
        e[n] = v[8 + 2 * n];
      end
      core_out = ~core_out;
      core_oe = ~core_oe;
      repeat (4) @(negedge clk_sys);
      check_pins(v[0], {v[5], v[3]}, {v[4], v[2]}, v[7], o, e);
    end
  endtask
  // Short chain: tdi reaches tdo after 118 shifts
  task t_reduced;
    begin
      reduced = 1'b1;
      repeat (4) @(negedge clk_sys);
      u_ctrl.load_ir(16'h0002);
      pat = ~{11{12'h5a3}};
      u_ctrl.scan_dr(pat, 124, cap);
      check(cap[117:0], exp_cap(1'b0));
      check(cap[123:118], pat[5:0]);
      reduced = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
  endtask
  task conclude;
    begin
      $display("Mismatches %0d, checks %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #400000;
    fail_count = fail_count + 1;
    conclude;
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    check({ext, pu_en, rst_pin_oe_b, tdo_oe_b, can_oe_b, pin_oe_b}, {4'h3, 2'h3, ~43'h0});
    rst_b = 1'b1;
    repeat (6) @(negedge clk_sys);
    check_pins(core_rst, core_can_out, core_can_oe, core_pu, core_out, core_oe);
    u_ctrl.reset_tap;
    t_sample;
    t_extest({11{12'h5a3}});
    pin_in = ~pin_in;
    can_in = ~can_in;
    rst_pin_in = 1'b0;
    xtal = 1'b1;
    core_pu = 1'b0;
    t_extest(~{11{12'h5a3}});
    t_reduced;
    u_ctrl.load_ir(16'hffff);
    repeat (4) @(negedge clk_sys);
    check_pins(core_rst, core_can_out, core_can_oe, core_pu, core_out, core_oe);
    // Other codes leave the chain alone: one bypass bit, captured as zero
    u_ctrl.scan_dr(pat, 8, cap);
    check(cap[7:0], {pat[6:0], 1'b0});
    conclude;
  end
endmodule // boundary_scan_data_register_test
